// ==== hdl/pcc_top.sv ====
/*
 PLL and core clock control block: AHB-Lite register slave, key protection,
 lock-loss handling, peripheral configuration, measurement requests,
 interrupt, and the core and metering clocks. Assumes one system clock, pins
 asynchronous to it, and the ADC acceptance strobes on the same clock.
*/
`timescale 1ns/1ps
`include "pcc_consts.svh"
module pcc_top (
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        hsel,
   input  wire logic [11:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   output logic             irq,
   input  wire logic        pll_clk,
   input  wire logic        pll_locked,
   input  wire logic        rx_pin,
   input  wire logic        switched_supply_main,
   input  wire logic        supply_ok_pin,
   input  wire logic        full_power_mode,
   input  wire logic        battery_operating_mode,
   input  wire logic        deep_sleep_mode,
   input  wire logic [2:0]  measure_accepted,
   output logic             sys_clk,
   output logic             core_clk,
   output logic             meter_clk,
   output logic             mcu_reset,
   output logic             meter_off,
   output logic             core_shutdown,
   output logic             timekeeping_unlock,
   output logic             external_reference_select,
   output logic [1:0]       receive_pin_function,
   output logic             rx_serial_select,
   output logic             rx_wake_enable,
   output logic [2:0]       measure_request
);
   pcc_pkg::pcc_state_t s;
   pcc_pkg::pcc_state_t next_s;
   pcc_clk_if           clk_bus ();

   logic [7:0] pins;
   logic       accept;
   logic       lock_fall;
   logic       rx_edge;
   logic [7:0] wbyte;
   logic [2:0] irq_events;
   logic [7:0] w1c_lock;
   logic [7:0] w1c_wake;
   logic [7:0] w1c_stat;

   // Hardware set wins over a software clear in the same cycle
   function automatic logic [7:0] pcc_w1c(input logic [7:0] cur,
                                          input logic [7:0] set,
                                          input logic [7:0] clr);
      pcc_w1c = (cur & ~clr) | set;
   endfunction : pcc_w1c

   function automatic logic [31:0] pcc_read(input pcc_pkg::pcc_state_t st);
      logic [7:0] b;
      b = 8'h00;
      case (st.idx)
         `PCC_IDX_KEY: begin
            b = st.unlock_key;
         end
         `PCC_IDX_POWER: begin
            b = st.power_clock_control;
         end
         `PCC_IDX_MEAS: begin
            b = {5'h00, st.measurement_start};
         end
         `PCC_IDX_PERIPHERAL_CONFIG_STATUS: begin
            b = {st.receive_wake_flag,
                 st.switched_supply_source,
                 st.supply_ok,
                 st.lock_loss_flag,
                 1'b0,
                 st.external_reference_select,
                 st.receive_pin_function};
         end
         `PCC_IDX_IRQ_STATUS: begin
            b = {5'h00, st.irq_status};
         end
         `PCC_IDX_IRQ_MASK: begin
            b = {5'h00, st.irq_mask};
         end
         default: begin
            b = 8'h00;
         end
      endcase
      pcc_read = {24'h000000, b};
   endfunction : pcc_read

   assign pins = {deep_sleep_mode, battery_operating_mode, full_power_mode,
                  supply_ok_pin, switched_supply_main, rx_pin, pll_locked, pll_clk};

   always_comb begin
      next_s = s;
      accept = hsel && htrans[1] && hready;
      wbyte = hwdata[7:0];
      irq_events = 3'h0;

      // Two-flop synchronisers; only sync2 is read by the logic
      next_s.sync1 = pins;
      next_s.sync2 = s.sync1;
      next_s.lock_prev = s.sync2[`PCC_IN_LOCKED];
      next_s.rx_prev = s.sync2[`PCC_IN_RX];
      lock_fall = s.lock_prev && !s.sync2[`PCC_IN_LOCKED];
      rx_edge = s.rx_prev != s.sync2[`PCC_IN_RX];

      next_s.sys_clk = s.sync2[`PCC_IN_PLL_CLK] && s.sync2[`PCC_IN_LOCKED];
      next_s.mcu_reset = !s.sync2[`PCC_IN_LOCKED];
      next_s.switched_supply_source = s.sync2[`PCC_IN_VSW_MAIN];
      next_s.supply_ok = s.sync2[`PCC_IN_VDD_OK];

      // Register write in the data phase
      if (s.phase == pcc_pkg::PCC_PH_WRITE) begin
         // Any write other than the key consumes the unlock
         next_s.key_state = pcc_pkg::PCC_KEY_LOCKED;
         case (s.idx)
            `PCC_IDX_KEY: begin
               next_s.unlock_key = wbyte;
               if (wbyte == `PCC_KEY_POWER_VALUE) begin
                  next_s.key_state = pcc_pkg::PCC_KEY_POWER;
               end else if (wbyte == `PCC_KEY_TIME_VALUE) begin
                  next_s.key_state = pcc_pkg::PCC_KEY_TIME;
               end
            end
            `PCC_IDX_POWER: begin
               if (s.key_state == pcc_pkg::PCC_KEY_POWER) begin
                  next_s.power_clock_control = wbyte & `PCC_POWER_WMASK;
               end
            end
            `PCC_IDX_MEAS: begin
               next_s.measurement_start = s.measurement_start | wbyte[2:0];
            end
            `PCC_IDX_PERIPHERAL_CONFIG_STATUS: begin
               next_s.external_reference_select = wbyte[2];
               next_s.receive_pin_function = wbyte[1:0];
            end
            `PCC_IDX_IRQ_MASK: begin
               next_s.irq_mask = wbyte[2:0];
            end
            default: begin
            end
         endcase
      end

      // Fault flag: lock loss sets, acknowledge bit clears, set wins
      w1c_lock = pcc_w1c({7'h00, s.lock_loss_flag},
                         {7'h00, lock_fall},
                         {7'h00, (s.phase == pcc_pkg::PCC_PH_WRITE) &&
                          (s.idx == `PCC_IDX_MEAS) &&
                          wbyte[`PCC_MEAS_ACK_BIT]});
      next_s.lock_loss_flag = w1c_lock[0];
      irq_events[`PCC_IRQ_LOCK_LOSS] = lock_fall;

      // Receive-edge wakeup flag, cleared by writing one to its bit
      irq_events[`PCC_IRQ_RX_WAKE] = rx_edge && s.sync2[`PCC_IN_DEEP_SLEEP] &&
                                     (s.receive_pin_function == `PCC_PER_RX_WAKE_FUNC);
      w1c_wake = pcc_w1c({7'h00, s.receive_wake_flag},
                         {7'h00, irq_events[`PCC_IRQ_RX_WAKE]},
                         {7'h00, (s.phase == pcc_pkg::PCC_PH_WRITE) &&
                          (s.idx == `PCC_IDX_PERIPHERAL_CONFIG_STATUS) &&
                          wbyte[`PCC_PER_RX_FLAG]});
      next_s.receive_wake_flag = w1c_wake[0];

      // Start bits drop when the ADC accepts; a new write in that cycle wins
      irq_events[`PCC_IRQ_MEAS_TAKEN] = |(s.measurement_start & measure_accepted);
      next_s.measurement_start = (s.measurement_start & ~measure_accepted) |
                                 (next_s.measurement_start & ~s.measurement_start) |
                                 (((s.phase == pcc_pkg::PCC_PH_WRITE) &&
                                   (s.idx == `PCC_IDX_MEAS)) ? wbyte[2:0] : 3'h0);

      w1c_stat = pcc_w1c({5'h00, s.irq_status}, {5'h00, irq_events},
                         {5'h00, ((s.phase == pcc_pkg::PCC_PH_WRITE) &&
                          (s.idx == `PCC_IDX_IRQ_STATUS)) ? wbyte[2:0] : 3'h0});
      next_s.irq_status = w1c_stat[2:0];

      // Bus phase: reads take one wait state so data come from a flop
      if (s.phase == pcc_pkg::PCC_PH_READ) begin
         next_s.hrdata = pcc_read(s);
         next_s.phase = pcc_pkg::PCC_PH_READ_OUT;
      end else if (accept) begin
         next_s.idx = haddr[11:2];
         if (hwrite) begin
            next_s.phase = pcc_pkg::PCC_PH_WRITE;
         end else begin
            next_s.phase = pcc_pkg::PCC_PH_READ;
            // A read between key and target breaks the unlock
            next_s.key_state = pcc_pkg::PCC_KEY_LOCKED;
         end
      end else begin
         next_s.phase = pcc_pkg::PCC_PH_IDLE;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         s <= '0;
         s.phase <= pcc_pkg::PCC_PH_IDLE;
         s.key_state <= pcc_pkg::PCC_KEY_LOCKED;
         s.power_clock_control <= `PCC_POWER_RESET;
         s.switched_supply_source <= 1'b1;
         s.mcu_reset <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign clk_bus.pll_level = s.sync2[`PCC_IN_PLL_CLK];
   assign clk_bus.pll_locked = s.sync2[`PCC_IN_LOCKED];
   assign clk_bus.core_clock_divider = s.power_clock_control[2:0];

   pcc_clock_divider #(
      .METER_DIV  (`PCC_METER_DIV),
      .METER_HIGH (`PCC_METER_HIGH)
   ) u_divider (
      .clk     (clk),
      .rst_b   (rst_b),
      .clk_bus (clk_bus)
   );

   assign hreadyout = (s.phase != pcc_pkg::PCC_PH_READ);
   assign hresp = 1'b0;
   assign hrdata = s.hrdata;
   assign irq = |(s.irq_status & s.irq_mask);
   assign sys_clk = s.sys_clk;
   assign core_clk = clk_bus.core_clk;
   assign meter_clk = clk_bus.meter_clk;
   assign mcu_reset = s.mcu_reset;
   assign meter_off = s.power_clock_control[`PCC_POWER_METER_OFF] &&
                      s.sync2[`PCC_IN_FULL_POWER];
   assign core_shutdown = s.power_clock_control[`PCC_POWER_CORE_OFF] &&
                          s.sync2[`PCC_IN_BATTERY];
   assign timekeeping_unlock = (s.key_state == pcc_pkg::PCC_KEY_TIME);
   assign external_reference_select = s.external_reference_select;
   assign receive_pin_function = s.receive_pin_function;
   // Code 10 is undefined and is treated as general purpose I/O
   assign rx_serial_select = s.receive_pin_function[0];
   assign rx_wake_enable = (s.receive_pin_function == `PCC_PER_RX_WAKE_FUNC);
   assign measure_request = s.measurement_start;

   // hsize is accepted but only whole-word transfers are expected
   logic unused_hsize;
   assign unused_hsize = ^hsize;
endmodule : pcc_top

// ==== hdl/pcc_consts.svh ====
/*
 Register indices, field positions, reset values and counts of the PLL and core
 clock control block. Assumes it is included by every file that uses its macros and
 holds definitions only.
*/
// Summary of operation
// - Stable 4.096 MHz system clock from locked PLL
// - Core clock is PLL clock over two-power divider
// - Divider resets to 010, core at 1.024 MHz
// - Metering clock is PLL over five, fixed
// - Power register written only after key 0xA7
// - Key 0xEA unlocks one timekeeping register write
// - Lock loss resets core, sets fault flag
// - Acknowledge bit seven clears the fault flag
// - Configuration bit four shows fault, resets zero
// - Power bit six stops metering in full power
// - Power bit four stops core in battery mode
// - Configuration bit seven marks receive-edge deep wakeup
// - Bit six shows supply source, resets one
// - Bit five shows main supply acceptable
// - Two-bit field selects receive pin function
// - Start bits request measurement, clear on acceptance
`ifndef PCC_CONSTS_SVH
`define PCC_CONSTS_SVH

`define PCC_IDX_KEY          10'h0C1
`define PCC_IDX_POWER        10'h0C5
`define PCC_IDX_MEAS         10'h0D8
`define PCC_IDX_PERIPHERAL_CONFIG_STATUS       10'h0F4
`define PCC_IDX_IRQ_STATUS   10'h100
`define PCC_IDX_IRQ_MASK     10'h101

`define PCC_KEY_POWER_VALUE  8'hA7
`define PCC_KEY_TIME_VALUE   8'hEA

`define PCC_POWER_RESET      8'h02
`define PCC_POWER_WMASK      8'h57
`define PCC_POWER_METER_OFF  6
`define PCC_POWER_CORE_OFF   4
`define PCC_MEAS_ACK_BIT     7
`define PCC_PER_RX_FLAG      7
`define PCC_PER_RX_WAKE_FUNC 2'h3

`define PCC_IRQ_LOCK_LOSS    0
`define PCC_IRQ_RX_WAKE      1
`define PCC_IRQ_MEAS_TAKEN   2

`define PCC_IN_PLL_CLK       0
`define PCC_IN_LOCKED        1
`define PCC_IN_RX            2
`define PCC_IN_VSW_MAIN      3
`define PCC_IN_VDD_OK        4
`define PCC_IN_FULL_POWER    5
`define PCC_IN_BATTERY       6
`define PCC_IN_DEEP_SLEEP    7

`define PCC_METER_DIV        3'h5
`define PCC_METER_HIGH       3'h2

`endif

// ==== hdl/pcc_pkg.sv ====
/*
 Types of the PLL and core clock control block: bus phases, key states and the
 packed state records of both modules. Assumes nothing beyond the compiler.
*/
package pcc_pkg;

   typedef enum logic [1:0] {
      PCC_PH_IDLE     = 2'b00,
      PCC_PH_WRITE    = 2'b01,
      PCC_PH_READ     = 2'b10,
      PCC_PH_READ_OUT = 2'b11
   } pcc_phase_t;

   typedef enum logic [1:0] {
      PCC_KEY_LOCKED = 2'b00,
      PCC_KEY_POWER  = 2'b01,
      PCC_KEY_TIME   = 2'b10
   } pcc_key_t;

   typedef struct packed {
      logic [7:0]  sync1;
      logic [7:0]  sync2;
      logic        lock_prev;
      logic        rx_prev;
      pcc_phase_t  phase;
      logic [9:0]  idx;
      logic [7:0]  unlock_key;
      pcc_key_t    key_state;
      logic [7:0]  power_clock_control;
      logic        receive_wake_flag;
      logic        switched_supply_source;
      logic        supply_ok;
      logic        lock_loss_flag;
      logic        external_reference_select;
      logic [1:0]  receive_pin_function;
      logic [2:0]  measurement_start;
      logic [2:0]  irq_status;
      logic [2:0]  irq_mask;
      logic [31:0] hrdata;
      logic        sys_clk;
      logic        mcu_reset;
   } pcc_state_t;

   typedef struct packed {
      logic       pll_prev;
      logic [6:0] count;
      logic [2:0] meter_count;
      logic       core_clk;
      logic       meter_clk;
   } pcc_div_state_t;

endpackage : pcc_pkg

// ==== hdl/pcc_clk_if.sv ====
/*
 Signals between the control top and its clock divider. Assumes both ends run
 on the same system clock.
*/
`timescale 1ns/1ps
interface pcc_clk_if;
   logic       pll_level;
   logic       pll_locked;
   logic [2:0] core_clock_divider;
   logic       core_clk;
   logic       meter_clk;

   modport ctrl (output pll_level, output pll_locked, output core_clock_divider,
                 input core_clk, input meter_clk);
   modport divider (input pll_level, input pll_locked, input core_clock_divider,
                    output core_clk, output meter_clk);
endinterface : pcc_clk_if

// ==== hdl/pcc_clock_divider.sv ====
/*
 Divides the synchronised PLL clock level into the core clock and the fixed
 metering clock. Assumes the PLL level is already synchronised to clk.
*/
`timescale 1ns/1ps
`include "pcc_consts.svh"
module pcc_clock_divider #(
   parameter logic [2:0] METER_DIV  = `PCC_METER_DIV,
   parameter logic [2:0] METER_HIGH = `PCC_METER_HIGH
) (
   input  wire logic  clk,
   input  wire logic  rst_b,
   pcc_clk_if.divider clk_bus
);
   pcc_pkg::pcc_div_state_t s;
   pcc_pkg::pcc_div_state_t next_s;
   logic                    pll_rise;

   always_comb begin
      next_s = s;
      pll_rise = clk_bus.pll_level && !s.pll_prev;
      next_s.pll_prev = clk_bus.pll_level;
      if (!clk_bus.pll_locked) begin
         // No output pulses from an unlocked PLL
         next_s.count = 7'h00;
         next_s.meter_count = 3'h0;
         next_s.core_clk = 1'b0;
         next_s.meter_clk = 1'b0;
      end else begin
         if (pll_rise) begin
            next_s.count = s.count + 7'h01;
            next_s.meter_count = (s.meter_count == METER_DIV - 3'h1) ? 3'h0 :
                                 s.meter_count + 3'h1;
         end
         if (clk_bus.core_clock_divider == 3'h0) begin
            next_s.core_clk = clk_bus.pll_level;
         end else begin
            next_s.core_clk = s.count[clk_bus.core_clock_divider - 3'h1];
         end
         // Independent of the core divider by construction
         next_s.meter_clk = (s.meter_count < METER_HIGH);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign clk_bus.core_clk  = s.core_clk;
   assign clk_bus.meter_clk = s.meter_clk;
endmodule : pcc_clock_divider

// ==== sim/pcc_top_props.sv ====
/*
 Port-level checks of the clock control block.
 Assumes a bind onto pcc_top and a PLL level with a fixed period.
*/
`timescale 1ns/1ps
module pcc_top_props (
   input wire logic       clk,
   input wire logic       rst_b,
   input wire logic       hsel,
   input wire logic [1:0] htrans,
   input wire logic       hwrite,
   input wire logic       hready,
   input wire logic       hreadyout,
   input wire logic       hresp,
   input wire logic       pll_locked,
   input wire logic       full_power_mode,
   input wire logic       battery_operating_mode,
   input wire logic [2:0] measure_accepted,
   input wire logic       sys_clk,
   input wire logic       meter_clk,
   input wire logic       mcu_reset,
   input wire logic       meter_off,
   input wire logic       core_shutdown,
   input wire logic       timekeeping_unlock,
   input wire logic [1:0] receive_pin_function,
   input wire logic       rx_serial_select,
   input wire logic       rx_wake_enable,
   input wire logic [2:0] measure_request
);
   logic       sys_d;
   logic       met_d;
   logic       armed;
   logic [3:0] rises;
   wire        sys_up  = sys_clk & ~sys_d;
   wire        met_up  = meter_clk & ~met_d;
   wire  [3:0] rises_n = rises + {3'h0, sys_up};

   // Counts PLL rises between metering rises; restarts after lock loss
   always_ff @(posedge clk) begin
      sys_d <= sys_clk;
      met_d <= meter_clk;
      if (!rst_b || mcu_reset) begin
         armed <= 1'b0;
         rises <= 4'h0;
      end else if (met_up) begin
         armed <= 1'b1;
         rises <= 4'h0;
      end else begin
         rises <= rises_n;
      end
   end

   okay_resp_a: assert property (@(posedge clk) disable iff (!rst_b) hresp == 1'b0)
      else $error("slave response not okay");
   read_wait_a: assert property (@(posedge clk) disable iff (!rst_b) !hreadyout |=> hreadyout)
      else $error("wait state longer than one cycle");
   sys_gate_a: assert property (@(posedge clk) disable iff (!rst_b) sys_clk |-> !mcu_reset)
      else $error("system clock runs while unlocked");
   lock_reset_a: assert property (@(posedge clk) disable iff (!rst_b)
      $fell(pll_locked) |-> ##[1:4] mcu_reset) else $error("no core reset on lock loss");
   meter_period_a: assert property (@(posedge clk) disable iff (!rst_b)
      met_up && armed && !mcu_reset |-> rises_n == 4'h5) else $error("metering period not five");
   meter_off_a: assert property (@(posedge clk) disable iff (!rst_b)
      !full_power_mode [*4] |-> !meter_off) else $error("metering off outside full power");
   core_off_a: assert property (@(posedge clk) disable iff (!rst_b)
      !battery_operating_mode [*4] |-> !core_shutdown) else $error("core off outside battery");
   pin_func_a: assert property (@(posedge clk) disable iff (!rst_b)
      rx_wake_enable == (receive_pin_function == 2'h3)
      && rx_serial_select == receive_pin_function[0]) else $error("pin function decode");
   meas_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
      (measure_request & measure_accepted) != 3'h0
      |=> (measure_request & $past(measure_accepted)) == 3'h0) else $error("request not cleared");
   unlock_once_a: assert property (@(posedge clk) disable iff (!rst_b)
      timekeeping_unlock && hsel && htrans[1] && hready && !hwrite |=> !timekeeping_unlock)
      else $error("unlock survives a read");
endmodule : pcc_top_props

bind pcc_top pcc_top_props chk (.clk(clk), .rst_b(rst_b), .hsel(hsel), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .pll_locked(pll_locked), .full_power_mode(full_power_mode),
   .battery_operating_mode(battery_operating_mode), .measure_accepted(measure_accepted),
   .sys_clk(sys_clk), .meter_clk(meter_clk), .mcu_reset(mcu_reset), .meter_off(meter_off),
   .core_shutdown(core_shutdown), .timekeeping_unlock(timekeeping_unlock),
   .receive_pin_function(receive_pin_function), .rx_serial_select(rx_serial_select),
   .rx_wake_enable(rx_wake_enable), .measure_request(measure_request));

// ==== sim/pcc_far_model.sv ====
/*
 Far side: PLL output level and the ADC taking measurement requests.
 Assumes the bench drives the lock pin; all changes follow a rising clk.
*/
`timescale 1ns/1ps
module pcc_far_model #(
   parameter int HALF = 15,
   parameter int LAT  = 4
) (
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic [2:0] measure_request,
   output logic            pll_clk,
   output logic [2:0]      measure_accepted
);
   int ph;
   int wait_n;
   initial begin
      pll_clk = 1'b0;
      measure_accepted = 3'h0;
      ph = 0;
      wait_n = 0;
   end
   // Only ratios matter, so the level runs near 4 MHz rather than exactly
   always @(posedge clk) begin
      ph <= (ph == HALF - 1) ? 0 : ph + 1;
      if (ph == HALF - 1) pll_clk <= ~pll_clk;
   end
   // A slow ADC: takes pending requests after LAT cycles, one-cycle strobe
   always @(posedge clk) begin
      if (!rst_b || measure_request == 3'h0 || measure_accepted != 3'h0) begin
         wait_n <= 0;
         measure_accepted <= 3'h0;
      end else if (wait_n == LAT) begin
         measure_accepted <= measure_request;
      end else begin
         wait_n <= wait_n + 1;
      end
   end
endmodule : pcc_far_model

// ==== sim/testbench.sv ====
/*
 Self-checking bench: AHB-Lite tasks and scenario sequence.
 Assumes the design header, the far-side model and the bound checker.
*/
`timescale 1ns/1ps
`include "pcc_consts.svh"
module testbench;
   localparam int         half   = 15;
   localparam logic [9:0] i_key  = `PCC_IDX_KEY;
   localparam logic [9:0] i_pow  = `PCC_IDX_POWER;
   localparam logic [9:0] i_meas = `PCC_IDX_MEAS;
   localparam logic [9:0] i_per  = `PCC_IDX_PERIPHERAL_CONFIG_STATUS;
   localparam logic [9:0] i_stat = `PCC_IDX_IRQ_STATUS;
   localparam logic [9:0] i_mask = `PCC_IDX_IRQ_MASK;
   logic        clk, rst_b, hsel, hwrite, hreadyout, hresp, irq, pll_clk, pll_locked, rx_pin;
   logic        switched_supply_main, supply_ok_pin, full_power_mode, battery_operating_mode;
   logic        deep_sleep_mode, sys_clk, core_clk, meter_clk, mcu_reset, meter_off;
   logic        core_shutdown, timekeeping_unlock, external_reference_select;
   logic        rx_serial_select, rx_wake_enable;
   logic [11:0] haddr;
   logic [1:0]  htrans, receive_pin_function;
   logic [2:0]  hsize, measure_accepted, measure_request;
   logic [31:0] hwdata, hrdata, q;
   int          mismatches, checks_done, cycles, n;
   logic [1:0]  n_codes [3] = '{2'h0, 2'h1, 2'h3};

   pcc_top uut (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq), .pll_clk(pll_clk),
      .pll_locked(pll_locked), .rx_pin(rx_pin), .switched_supply_main(switched_supply_main),
      .supply_ok_pin(supply_ok_pin), .full_power_mode(full_power_mode),
      .battery_operating_mode(battery_operating_mode), .deep_sleep_mode(deep_sleep_mode),
      .measure_accepted(measure_accepted), .sys_clk(sys_clk), .core_clk(core_clk),
      .meter_clk(meter_clk), .mcu_reset(mcu_reset), .meter_off(meter_off),
      .core_shutdown(core_shutdown), .timekeeping_unlock(timekeeping_unlock),
      .external_reference_select(external_reference_select),
      .receive_pin_function(receive_pin_function), .rx_serial_select(rx_serial_select),
      .rx_wake_enable(rx_wake_enable), .measure_request(measure_request));
   pcc_far_model #(.HALF(half), .LAT(4)) far (.clk(clk), .rst_b(rst_b),
      .measure_request(measure_request), .pll_clk(pll_clk), .measure_accepted(measure_accepted));

   initial clk = 1'b0;
   always #4 clk = ~clk;

   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : conclude

   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         mismatches++;
         conclude();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic tick(input int k);
      repeat (k) @(posedge clk);
   endtask : tick

   // Holds each phase until hready is seen high; read data taken at that edge
   task automatic bus(input logic wr_en, input logic [9:0] idx, input logic [7:0] d);
      hsel <= 1'b1;
      haddr <= {idx, 2'b00};
      htrans <= 2'b10;
      hwrite <= wr_en;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h0, d};
      do @(posedge clk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask : bus

   task automatic wr(input logic [9:0] idx, input logic [7:0] d);
      bus(1'b1, idx, d);
   endtask : wr

   task automatic rd(input logic [9:0] idx, input logic [7:0] exp);
      bus(1'b0, idx, 8'h00);
      chk(q, {24'h0, exp});
   endtask : rd

   task automatic pw(input logic [7:0] d);
      wr(i_key, `PCC_KEY_POWER_VALUE);
      wr(i_pow, d);
   endtask : pw

   // Cycles between two rises of the selected clock; 0 core, 1 metering, 2 system
   task automatic measure(input int sel, output int cnt);
      int   edges;
      logic prev;
      logic cur;
      edges = 0;
      cnt = 0;
      prev = 1'b1;
      while (edges < 2) begin
         @(posedge clk);
         cur = (sel == 0) ? core_clk : (sel == 1) ? meter_clk : sys_clk;
         if (cur && !prev) edges++;
         if (edges == 1) cnt++;
         prev = cur;
      end
   endtask : measure

   initial begin
      rst_b = 1'b0; hsel = 1'b0; haddr = 12'h000; htrans = 2'h0; hwrite = 1'b0;
      hsize = 3'h2; hwdata = 32'h0; pll_locked = 1'b1; rx_pin = 1'b0;
      switched_supply_main = 1'b1; supply_ok_pin = 1'b1; full_power_mode = 1'b0;
      battery_operating_mode = 1'b0; deep_sleep_mode = 1'b0;
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      tick(4);
      rd(i_key, 8'h00);
      rd(i_pow, 8'h02);
      measure(0, n);
      chk(n, (2 * half) << 2);
      rd(i_meas, 8'h00);
      rd(i_per, 8'h60);
      switched_supply_main <= 1'b0;
      supply_ok_pin <= 1'b0;
      tick(5);
      rd(i_per, 8'h00);
      switched_supply_main <= 1'b1;
      supply_ok_pin <= 1'b1;
      wr(i_pow, 8'h43);
      rd(i_pow, 8'h02);
      pw(8'h43);
      rd(i_pow, 8'h43);
      wr(i_key, `PCC_KEY_POWER_VALUE);
      bus(1'b0, i_key, 8'h00);
      wr(i_pow, 8'h02);
      rd(i_pow, 8'h43);
      pw(8'hFF);
      rd(i_pow, 8'h57);
      full_power_mode <= 1'b1;
      battery_operating_mode <= 1'b1;
      tick(5);
      chk({meter_off, core_shutdown}, 2'b11);
      full_power_mode <= 1'b0;
      battery_operating_mode <= 1'b0;
      wr(i_key, `PCC_KEY_TIME_VALUE);
      tick(1);
      chk(timekeeping_unlock, 1'b1);
      rd(10'h200, 8'h00);
      tick(1);
      chk(timekeeping_unlock, 1'b0);
      for (int cd = 0; cd < 8; cd++) begin
         pw(8'(cd));
         measure(0, n);
         measure(0, n);
         chk(n, (2 * half) << cd);
      end
      measure(1, n);
      chk(n, 10 * half);
      measure(2, n);
      chk(n, 2 * half);
      pll_locked <= 1'b0;
      tick(6);
      chk({mcu_reset, irq}, 2'b10);
      pll_locked <= 1'b1;
      tick(6);
      rd(i_per, 8'h70);
      rd(i_stat, 8'h01);
      wr(i_mask, 8'h01);
      tick(1);
      chk(irq, 1'b1);
      wr(i_meas, 8'h80);
      rd(i_per, 8'h60);
      rd(i_meas, 8'h00);
      wr(i_stat, 8'h01);
      tick(1);
      chk(irq, 1'b0);
      wr(i_mask, 8'h04);
      wr(i_meas, 8'h07);
      tick(1);
      chk(measure_request, 3'h7);
      tick(10);
      chk({measure_request, irq}, 4'h1);
      rd(i_stat, 8'h04);
      wr(i_stat, 8'h04);
      foreach (n_codes[i]) begin
         wr(i_per, {6'h0, n_codes[i]});
         tick(1);
         chk({rx_wake_enable, rx_serial_select}, {n_codes[i] == 2'h3, n_codes[i][0]});
         chk(receive_pin_function, n_codes[i]);
      end
      wr(i_per, 8'h07);
      tick(1);
      chk(external_reference_select, 1'b1);
      wr(i_mask, 8'h02);
      deep_sleep_mode <= 1'b1;
      rx_pin <= 1'b1;
      tick(6);
      rd(i_per, 8'hE7);
      chk(irq, 1'b1);
      wr(i_per, 8'h87);
      rd(i_per, 8'h67);
      wr(i_stat, 8'h02);
      tick(1);
      chk(irq, 1'b0);
      conclude();
   end

endmodule : testbench
